// ==== logic/ulpb_defines.svh ====
// Constants for the transceiver-side bus mode block: timing, field positions, reset values.
// Assumes inclusion by bare name from the bus module and the bench; definitions only.
`ifndef ULPB_DEFINES_SVH
`define ULPB_DEFINES_SVH

`define ULPB_DATA_W        8
`define ULPB_IDLE_BYTE     8'h00
`define ULPB_LP_LS_LSB     0
`define ULPB_LP_INT_BIT    3
`define ULPB_CLK_DIV_HALF  4'h1
`define ULPB_EXIT_HOLD_CYC 2'h2
`define ULPB_RXCMD_INT_BIT 4

`endif

// ==== logic/ulpb_phy_bus.sv ====
// Transceiver side of the ULPI bus: synchronous and low-power bus modes.
// Assumes clk_i is the core clock; ulpi_clk_i is the interface clock domain
// that the link also uses. Core control levels pass through two-flop synchronisers, while rx and read bytes are sampled directly; commands return by a toggle.
`timescale 1ns/10ps
`include "ulpb_defines.svh"
module ulpb_phy_bus
(
	input  wire logic       clk_i,
	input  wire logic       rst_b_i,
	input  wire logic       ulpi_clk_i,
	input  wire logic       ref_clk_ok_i,
	input  wire logic [7:0] data_i,
	output logic      [7:0] data_o,
	output logic            data_oe_o,
	output logic            dir_o,
	output logic            nxt_o,
	input  wire logic       stp_i,
	input  wire logic       suspend_req_i,
	input  wire logic [1:0] line_state_i,
	input  wire logic       int_pending_i,
	input  wire logic       rx_valid_i,
	input  wire logic [7:0] rx_byte_i,
	input  wire logic       reg_rd_req_i,
	input  wire logic [7:0] reg_rd_data_i,
	output logic            clk_out_o,
	output logic            tx_start_o,
	output logic [7:0]      tx_cmd_o,
	output logic            lowpwr_o
);
	import ulpb_pkg::*;

	logic        rst_meta;
	logic        rst_sync_b;
	logic        ulpi_rst_b;
	logic [4:0]  core_in;
	logic [4:0]  link_in;
	logic [1:0]  ls_sync;
	logic        ref_ok;
	logic        ref_ok_core;
	logic        int_pend;
	logic        rx_val;
	logic        rd_req;
	ulpb_state_t state;
	ulpb_state_t next_state;
	logic        int_seen;
	logic        want_bus;
	logic [3:0]  div_cnt;
	logic        tx_tgl;
	logic [7:0]  tx_hold;
	logic [2:0]  tx_tgl_s;
	logic [1:0]  lp_meta;
	logic        send_rd;
	logic [1:0]  exit_cnt;

	// Reset is released through two flops so all core-clock logic leaves reset together.
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			rst_meta   <= 1'b0;
			rst_sync_b <= 1'b0;
		end
		else
		begin
			rst_meta   <= 1'b1;
			rst_sync_b <= rst_meta;
		end
	end

	// The link domain gets its own reset release on its own clock.
	ulpb_sync #(.WIDTH(1)) u_rst_link
	(
		.clk_i   (ulpi_clk_i),
		.rst_b_i (rst_b_i),
		.d_i     (1'b1),
		.q_o     (ulpi_rst_b)
	);

	// Core-side levels cross into the link domain by two flops each.
	assign core_in = {reg_rd_req_i, rx_valid_i, int_pending_i, ref_clk_ok_i, suspend_req_i};
	ulpb_sync #(.WIDTH(5)) u_sync_in
	(
		.clk_i   (ulpi_clk_i),
		.rst_b_i (ulpi_rst_b),
		.d_i     (core_in),
		.q_o     (link_in)
	);
	assign ref_ok   = link_in[1];
	assign int_pend = link_in[2];
	assign rx_val   = link_in[3];
	assign rd_req   = link_in[4];

	// Line state is sampled by two flops before the bus logic sees it.
	ulpb_sync #(.WIDTH(2)) u_sync_ls
	(
		.clk_i   (ulpi_clk_i),
		.rst_b_i (ulpi_rst_b),
		.d_i     (line_state_i),
		.q_o     (ls_sync)
	);

	// The reference-good level comes from outside, so it passes two flops
	// before the divider reads it.
	ulpb_sync #(.WIDTH(1)) u_sync_ref
	(
		.clk_i   (clk_i),
		.rst_b_i (rst_sync_b),
		.d_i     (ref_clk_ok_i),
		.q_o     (ref_ok_core)
	);

	// Interface clock out, derived from the core clock only once the
	// reference is reported good; it stays low otherwise.
	always_ff @(posedge clk_i or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
		begin
			div_cnt   <= 4'h0;
			clk_out_o <= 1'b0;
		end
		else if (!ref_ok_core)
		begin
			div_cnt   <= 4'h0;
			clk_out_o <= 1'b0;
		end
		else if (div_cnt == `ULPB_CLK_DIV_HALF)
		begin
			div_cnt   <= 4'h0;
			clk_out_o <= ~clk_out_o;
		end
		else
		begin
			div_cnt <= div_cnt + 4'h1;
		end
	end

	// The bus wants to drive when it has receive data, read data or a
	// persisting interrupt change to report.
	assign want_bus = rx_val | rd_req | int_seen;

	// Bus sequencer. Every direction change passes a turnaround state.
	always_comb
	begin
		next_state = state;
		case (state)
			ULPB_ST_LOWPWR:
				// Wake needs stop held and a running reference.
				if (stp_i && ref_ok && exit_cnt == `ULPB_EXIT_HOLD_CYC)
					next_state = ULPB_ST_TURN_D;
			ULPB_ST_IDLE:
				if (link_in[0])
					next_state = ULPB_ST_TURN_U;
				else if (want_bus && data_i == `ULPB_IDLE_BYTE)
					next_state = ULPB_ST_TURN_U;
				else if (data_i != `ULPB_IDLE_BYTE)
					next_state = ULPB_ST_RXTX;
			ULPB_ST_TURN_U:
				if (link_in[0])
					next_state = ULPB_ST_LOWPWR;
				else
					next_state = ULPB_ST_SEND;
			ULPB_ST_SEND:
				// Stop from the link aborts the send.
				if (stp_i || !want_bus)
					next_state = ULPB_ST_TURN_D;
			ULPB_ST_TURN_D:
				next_state = ULPB_ST_IDLE;
			ULPB_ST_RXTX:
				if (stp_i)
					next_state = ULPB_ST_IDLE;
			default:
				next_state = ULPB_ST_IDLE;
		endcase
	end

	// After reset the bus is in synchronous mode, direction low.
	always_ff @(posedge ulpi_clk_i or negedge ulpi_rst_b)
	begin
		if (!ulpi_rst_b)
			state <= ULPB_ST_IDLE;
		else
			state <= next_state;
	end

	// Stop is counted while held in low power so one glitch cannot wake us.
	always_ff @(posedge ulpi_clk_i or negedge ulpi_rst_b)
	begin
		if (!ulpi_rst_b)
			exit_cnt <= 2'h0;
		else if (state != ULPB_ST_LOWPWR || !stp_i)
			exit_cnt <= 2'h0;
		else if (exit_cnt != `ULPB_EXIT_HOLD_CYC)
			exit_cnt <= exit_cnt + 2'h1;
	end

	// Interrupt changes seen during suspend are remembered; the status byte
	// is sent on wake only if the condition still holds.
	always_ff @(posedge ulpi_clk_i or negedge ulpi_rst_b)
	begin
		if (!ulpi_rst_b)
			int_seen <= 1'b0;
		else if (state == ULPB_ST_LOWPWR && int_pend)
			int_seen <= 1'b1;
		else if (state == ULPB_ST_SEND && !nxt_o)
			int_seen <= 1'b0;
		else if (!int_pend)
			int_seen <= 1'b0;
	end

	// Read data takes priority over the status byte in a no-next cycle.
	always_ff @(posedge ulpi_clk_i or negedge ulpi_rst_b)
	begin
		if (!ulpi_rst_b)
			send_rd <= 1'b0;
		else
			send_rd <= rd_req && !rx_val;
	end

	// Direction, next and data outputs, all registered.
	always_ff @(posedge ulpi_clk_i or negedge ulpi_rst_b)
	begin
		if (!ulpi_rst_b)
		begin
			dir_o     <= 1'b0;
			nxt_o     <= 1'b0;
			data_o    <= `ULPB_IDLE_BYTE;
			data_oe_o <= 1'b0;
		end
		else
		begin
			case (next_state)
				ULPB_ST_LOWPWR:
				begin
					dir_o     <= 1'b1;
					nxt_o     <= 1'b0;
					data_oe_o <= 1'b1;
					// Reserved lines low, interrupt on line 3.
					data_o    <= {4'h0, int_pend, 1'b0, ls_sync};
				end
				ULPB_ST_TURN_U, ULPB_ST_TURN_D:
				begin
					dir_o     <= (next_state == ULPB_ST_TURN_U);
					nxt_o     <= 1'b0;
					data_oe_o <= 1'b0;
					data_o    <= `ULPB_IDLE_BYTE;
				end
				ULPB_ST_SEND:
				begin
					dir_o     <= 1'b1;
					data_oe_o <= 1'b1;
					// Next marks exactly the valid receive bytes.
					nxt_o     <= rx_val;
					if (rx_val)
						data_o <= rx_byte_i;
					else if (send_rd)
						data_o <= reg_rd_data_i;
					else
						data_o <= {3'b000, int_pend, 2'b00, ls_sync}; // Interrupt on bit 4
				end
				ULPB_ST_RXTX:
				begin
					dir_o     <= 1'b0;
					nxt_o     <= !stp_i;
					data_oe_o <= 1'b0;
					data_o    <= `ULPB_IDLE_BYTE;
				end
				default:
				begin
					dir_o     <= 1'b0;
					nxt_o     <= 1'b0;
					data_oe_o <= 1'b0;
					data_o    <= `ULPB_IDLE_BYTE;
				end
			endcase
		end
	end

	// A new transmit command is captured and announced by a toggle.
	always_ff @(posedge ulpi_clk_i or negedge ulpi_rst_b)
	begin
		if (!ulpi_rst_b)
		begin
			tx_tgl  <= 1'b0;
			tx_hold <= `ULPB_IDLE_BYTE;
		end
		else if (state == ULPB_ST_IDLE && next_state == ULPB_ST_RXTX)
		begin
			tx_tgl  <= ~tx_tgl;
			tx_hold <= data_i;
		end
	end

	// Toggle crossing to the core domain; the held byte is stable by then.
	always_ff @(posedge clk_i or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
		begin
			tx_tgl_s   <= 3'b000;
			tx_start_o <= 1'b0;
			tx_cmd_o   <= `ULPB_IDLE_BYTE;
		end
		else
		begin
			tx_tgl_s   <= {tx_tgl_s[1:0], tx_tgl};
			tx_start_o <= tx_tgl_s[2] ^ tx_tgl_s[1];
			if (tx_tgl_s[2] ^ tx_tgl_s[1])
				tx_cmd_o <= tx_hold;
		end
	end

	// Low-power status level crossed back to the core domain.
	always_ff @(posedge clk_i or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
		begin
			lp_meta  <= 2'b00;
			lowpwr_o <= 1'b0;
		end
		else
		begin
			lp_meta  <= {lp_meta[0], state == ULPB_ST_LOWPWR};
			lowpwr_o <= lp_meta[1];
		end
	end
endmodule // ulpb_phy_bus

// ==== logic/ulpb_pkg.sv ====
// Types shared by the bus mode block.
// Assumes the defines header is available on the include path.
package ulpb_pkg;
	// Bus-side sequencer states.
	typedef enum logic [2:0]
	{
		ULPB_ST_LOWPWR = 3'b000,
		ULPB_ST_IDLE   = 3'b001,
		ULPB_ST_TURN_U = 3'b010,
		ULPB_ST_SEND   = 3'b011,
		ULPB_ST_TURN_D = 3'b100,
		ULPB_ST_RXTX   = 3'b101
	} ulpb_state_t;
endpackage

// ==== logic/ulpb_sync.sv ====
// Two-flop level synchroniser, one bit per generate entry.
// Assumes an asynchronous active-low reset in the destination domain.
`timescale 1ns/10ps
module ulpb_sync
#(
	parameter int WIDTH = 1
)
(
	input  wire logic             clk_i,
	input  wire logic             rst_b_i,
	input  wire logic [WIDTH-1:0] d_i,
	output logic      [WIDTH-1:0] q_o
);
	// Only the second stage is read outside, keeping metastability contained.
	generate
		for (genvar i = 0; i < WIDTH; i++)
		begin : g_bit
			logic meta;
			always_ff @(posedge clk_i or negedge rst_b_i)
			begin
				if (!rst_b_i)
				begin
					meta   <= 1'b0;
					q_o[i] <= 1'b0;
				end
				else
				begin
					meta   <= d_i[i];
					q_o[i] <= meta;
				end
			end
		end
	endgenerate
endmodule // ulpb_sync

// ==== verif/ulpb_link_model.sv ====
// Link controller model: sends commands, stops, aborts and wakes.
// Assumes it runs on the bus clock and changes lines at its falling edge.
`timescale 1ns/10ps
module ulpb_link_model
(
	input  wire logic       ulpi_clk_i,
	input  wire logic       dir_o,
	input  wire logic       nxt_o,
	output logic      [7:0] data_i,
	output logic            stp_i
);
	logic busy;
	logic acc;

	// Idle bus is zero; a released bus toggles so stale data never looks valid.
	always @(negedge ulpi_clk_i)
		if (!busy)
			data_i <= dir_o ? ~data_i : 8'h00;

	// One command plus n bytes, then a single stop cycle.
	task automatic send(input logic [7:0] cmd, input int n);
		int m;
		busy = 1'b1;
		while (dir_o) @(negedge ulpi_clk_i);
		@(negedge ulpi_clk_i);
		data_i = cmd;
		acc = 1'b0;
		m = 0;
		for (int w = 0; m <= n && w < 40; w++)
		begin
			@(negedge ulpi_clk_i);
			if (acc)
			begin
				m++;
				data_i = (m > n) ? 8'h00 : 8'(cmd + m);
				stp_i = (m > n);
			end
			acc = nxt_o;
		end
		@(negedge ulpi_clk_i);
		stp_i = 1'b0;
		busy = 1'b0;
	endtask

	// Stop pulse while the bus is turned toward the link.
	task automatic abort();
		@(negedge ulpi_clk_i);
		stp_i = 1'b1;
		@(negedge ulpi_clk_i);
		stp_i = 1'b0;
	endtask

	// Hold stop until the bus turns back; the bench restarts the clock first.
	task automatic wake();
		@(negedge ulpi_clk_i);
		stp_i = 1'b1;
		for (int w = 0; w < 20 && dir_o; w++)
			@(negedge ulpi_clk_i);
		stp_i = 1'b0;
	endtask

	initial
	begin
		busy = 1'b0;
		stp_i = 1'b0;
		data_i = 8'h00;
	end
endmodule // ulpb_link_model

// ==== verif/ulpb_phy_bus_sva.sv ====
// Port checker for the bus mode block, bus clock domain only.
// Assumes it is bound onto ulpb_phy_bus.
`timescale 1ns/10ps
module ulpb_phy_bus_sva
(
	input wire logic       clk_i,
	input wire logic       rst_b_i,
	input wire logic       ulpi_clk_i,
	input wire logic       ref_clk_ok_i,
	input wire logic       stp_i,
	input wire logic [7:0] data_o,
	input wire logic       data_oe_o,
	input wire logic       dir_o,
	input wire logic       nxt_o,
	input wire logic       lowpwr_o
);
	// Every check samples the bus clock; reset masks them all.
	default clocking cb @(posedge ulpi_clk_i); endclocking
	default disable iff (!rst_b_i);

	// The low-power level lags the bus by its crossing, so dir falls first on wake.
	a_lp_dir_high: assert property (lowpwr_o && !dir_o |-> ##[1:3] !lowpwr_o)
		else $error("dir low in low power");
	a_lp_lines_low: assert property
		(lowpwr_o && data_oe_o |-> (data_o & 8'hF4) == 8'h00) else $error("reserved line high");
	a_turn_no_drive: assert property ($changed(dir_o) |-> !data_oe_o)
		else $error("driven in turnaround");
	a_oe_with_dir: assert property (data_oe_o |-> dir_o)
		else $error("drive with dir low");
	a_stp_ends_nxt: assert property (!dir_o && nxt_o && stp_i |-> ##[1:2] !nxt_o)
		else $error("nxt after stop");
	a_stp_drops_dir: assert property (dir_o && !lowpwr_o && stp_i |-> ##[1:2] !dir_o)
		else $error("dir kept after stop");
	a_lp_wake: assert property
		((lowpwr_o && stp_i && ref_clk_ok_i)[*3] |-> ##[0:4] !lowpwr_o) else $error("no wake");
	a_sync_default: assert property ($rose(rst_b_i) |-> (!lowpwr_o && !dir_o)[*2])
		else $error("not synchronous after reset");

	// Main scenarios: low power, receive data, abort.
	c_lp: cover property (lowpwr_o);
	c_rx: cover property (dir_o && nxt_o);
	c_abort: cover property (dir_o && stp_i && !lowpwr_o);
endmodule // ulpb_phy_bus_sva

bind ulpb_phy_bus ulpb_phy_bus_sva u_sva
(
	.clk_i, .rst_b_i, .ulpi_clk_i, .ref_clk_ok_i, .stp_i,
	.data_o, .data_oe_o, .dir_o, .nxt_o, .lowpwr_o
);

// ==== verif/ulpb_phy_bus_test.sv ====
// Self-checking bench for the bus mode block with a link model.
// Assumes the defines header is on the include path.
`timescale 1ns/10ps
`include "ulpb_defines.svh"
module ulpb_phy_bus_test;
	logic       clk_i, ulpi_clk_i, rst_b_i, ref_clk_ok_i, stp_i, suspend_req_i;
	logic       data_oe_o, dir_o, nxt_o, int_pending_i, rx_valid_i, reg_rd_req_i;
	logic       clk_out_o, tx_start_o, lowpwr_o, prev;
	logic [1:0] line_state_i;
	logic [7:0] data_i, data_o, rx_byte_i, reg_rd_data_i, tx_cmd_o, got, exp, starts;
	int         seed, num_errors, checks, i, k;

	ulpb_phy_bus DUT
	(
		.clk_i, .rst_b_i, .ulpi_clk_i, .ref_clk_ok_i, .data_i, .data_o, .data_oe_o,
		.dir_o, .nxt_o, .stp_i, .suspend_req_i, .line_state_i, .int_pending_i,
		.rx_valid_i, .rx_byte_i, .reg_rd_req_i, .reg_rd_data_i, .clk_out_o,
		.tx_start_o, .tx_cmd_o, .lowpwr_o
	);
	ulpb_link_model lk (.ulpi_clk_i, .dir_o, .nxt_o, .data_i, .stp_i);

	// Core clock 100 ns; bus clock 160 ns on an unrelated phase.
	initial
	begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	initial
	begin
		ulpi_clk_i = 1'b0;
		#37;
		forever #80 ulpi_clk_i = ~ulpi_clk_i;
	end

	// Count command pulses at the falling edge, where they are settled.
	always @(negedge clk_i)
		if (tx_start_o === 1'b1)
		begin
			starts <= starts + 8'h01;
			got <= tx_cmd_o;
		end

	function automatic logic [7:0] lp_byte(input logic irq, input logic [1:0] ls);
		return {4'h0, irq, 1'b0, ls};
	endfunction

	task automatic check(input logic [7:0] val, input logic [7:0] want, input string what);
		checks++;
		if (val !== want)
		begin
			num_errors++;
			$display("wrong value at %0t: %s got %h want %h", $time, what, val, want);
		end
	endtask

	task automatic wait_dir(input logic lvl, input int lim);
		for (int w = 0; w < lim && dir_o !== lvl; w++)
			@(negedge ulpi_clk_i);
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// A hang costs one mismatch and ends the run the normal way.
	initial
	begin
		#300000;
		num_errors++;
		end_sim();
	end

	// Main sequence: reset, commands, receive path, low power.
	initial
	begin
		seed = 12;
		{rst_b_i, suspend_req_i, int_pending_i, rx_valid_i, reg_rd_req_i} = '0;
		{line_state_i, rx_byte_i, reg_rd_data_i, starts, got} = '0;
		ref_clk_ok_i = 1'b1;
		repeat (16) @(negedge clk_i);
		rst_b_i = 1'b1;
		repeat (4) @(negedge ulpi_clk_i);
		check({7'h0, dir_o}, 8'h00, "dir");
		check({7'h0, lowpwr_o}, 8'h00, "lowpwr");
		$display("test reset done");
		for (i = 0; i < 6; i++)
		begin
			exp = (i == 0) ? 8'h01 : (i == 1) ? 8'hFF : 8'($random(seed));
			exp = (exp == 8'h00) ? 8'h5A : exp;
			lk.send(exp, i % 4);
			repeat (8) @(negedge clk_i);
			check(got, exp, "command");
			check(starts, 8'(i + 1), "pulses");
		end
		k = 0;
		prev = clk_out_o;
		repeat (8)
		begin
			@(negedge clk_i);
			k += (clk_out_o !== prev);
			prev = clk_out_o;
		end
		check({7'h0, k > 0}, 8'h01, "clock out runs");
		$display("test command done");
		@(negedge clk_i);
		rx_byte_i = 8'($random(seed));
		rx_valid_i = 1'b1;
		wait_dir(1'b1, 20);
		check({7'h0, data_oe_o}, 8'h00, "turnaround");
		@(negedge ulpi_clk_i);
		check({6'h0, dir_o, nxt_o}, 8'h03, "rx flags");
		check(data_o, rx_byte_i, "rx byte");
		lk.abort();
		wait_dir(1'b0, 3);
		check({7'h0, dir_o}, 8'h00, "abort");
		@(negedge clk_i);
		rx_valid_i = 1'b0;
		reg_rd_data_i = 8'($random(seed));
		// The late receive level may still cost one status send; let it finish.
		repeat (8) @(negedge ulpi_clk_i);
		wait_dir(1'b0, 20);
		@(negedge clk_i);
		reg_rd_req_i = 1'b1;
		wait_dir(1'b1, 20);
		@(negedge ulpi_clk_i);
		check({7'h0, nxt_o}, 8'h00, "read nxt");
		check(data_o, reg_rd_data_i, "read byte");
		@(negedge clk_i);
		reg_rd_req_i = 1'b0;
		wait_dir(1'b0, 20);
		check({7'h0, dir_o}, 8'h00, "dir back");
		$display("test receive done");
		@(negedge clk_i);
		line_state_i = 2'($random(seed));
		suspend_req_i = 1'b1;
		for (k = 0; k < 20 && lowpwr_o !== 1'b1; k++)
			@(negedge ulpi_clk_i);
		repeat (4) @(negedge ulpi_clk_i);
		check({6'h0, lowpwr_o, dir_o}, 8'h03, "low power");
		check(data_o, lp_byte(1'b0, line_state_i), "lp map");
		@(negedge clk_i);
		int_pending_i = 1'b1;
		ref_clk_ok_i = 1'b0;
		repeat (12) @(negedge clk_i);
		check(data_o, lp_byte(1'b1, line_state_i), "lp int");
		check({7'h0, clk_out_o}, 8'h00, "clock stopped");
		ref_clk_ok_i = 1'b1;
		suspend_req_i = 1'b0;
		repeat (12) @(negedge clk_i);
		lk.wake();
		wait_dir(1'b1, 20);
		@(negedge ulpi_clk_i);
		check({7'h0, data_o[`ULPB_RXCMD_INT_BIT]}, 8'h01, "wake status");
		// The low-power level crosses to the core clock, so it is looked at late.
		check({7'h0, lowpwr_o}, 8'h00, "woken");
		@(negedge clk_i);
		int_pending_i = 1'b0;
		wait_dir(1'b0, 20);
		$display("test low power done");
		end_sim();
	end
endmodule // ulpb_phy_bus_test
